// ---- pkg/pobs_map.svh ----
`ifndef POBS_MAP_SVH
`define POBS_MAP_SVH

// Widths
`define POBS_ADC_W       12
`define POBS_SET_W       10
`define POBS_SUM_W       11
`define POBS_ADDR_W      5

// Register byte offsets
`define POBS_REG_GAIN_SEL 5'h00
`define POBS_REG_GAIN_VAL 5'h04
`define POBS_REG_OFF_SEL  5'h08
`define POBS_REG_OFF_VAL  5'h0C
`define POBS_REG_CTRL     5'h10
`define POBS_REG_STATUS   5'h14
`define POBS_REG_GAIN_TOT 5'h18

// Control and status field positions
`define POBS_CTRL_SHIFT_LSB 0
`define POBS_CTRL_FMT12_BIT 3
`define POBS_CTRL_AGC_BIT   4
`define POBS_STAT_SAT_BIT   0
`define POBS_STAT_CNT_LSB   16

// Reset values
`define POBS_RST_SET     10'h000
`define POBS_RST_SHIFT   3'h0
`define POBS_RST_FMT12   1'b0
`define POBS_RST_AGC     1'b0

// Limits and scaling
`define POBS_OFF_MAX     10'h258
`define POBS_SHIFT_MAX   3'h4
`define POBS_OFF_DROP    2

`endif

// ---- pkg/pobs_pkg.sv ----
`include "pobs_map.svh"

package pobs_pkg;

  typedef logic [`POBS_ADC_W-1:0] pobs_adc_t;
  typedef logic [`POBS_SET_W-1:0] pobs_set_t;
  typedef logic [`POBS_SUM_W-1:0] pobs_sum_t;

  typedef enum logic [1:0] {
    sel_all   = 2'b00,
    sel_right = 2'b01,
    sel_left  = 2'b10
  } pobs_sel_e;

  typedef struct packed {
    logic      valid;
    logic      tap;
    pobs_adc_t data;
  } pobs_adc_s;

  typedef struct packed {
    logic      valid;
    logic      half;
    pobs_adc_t data;
    logic      sat;
  } pobs_pix_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    pobs_sel_e   gsel;
    pobs_sel_e   osel;
    pobs_set_t   g_all;
    pobs_set_t   g_r;
    pobs_set_t   g_l;
    pobs_set_t   o_all;
    pobs_set_t   o_r;
    pobs_set_t   o_l;
    logic [2:0]  shift;
    logic        fmt12;
    logic        agc_en;
    logic        sat_seen;
    logic [15:0] pix_cnt;
    pobs_sum_t   gr_tot;
    pobs_sum_t   gl_tot;
    pobs_pix_s   pix;
  } pobs_state_s;

  function automatic logic [2:0] pobs_shift_n(input logic [2:0] code);
    return (code > `POBS_SHIFT_MAX) ? 3'h0 : code;
  endfunction

  function automatic pobs_adc_t pobs_hi_mask(input logic [2:0] code);
    return ~(12'hFFF >> pobs_shift_n(code));
  endfunction

endpackage

// ---- rtl/pobs_top.sv ----
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "pobs_map.svh"

module pobs_top
  import pobs_pkg::*;
(
  // Clock and reset
  input  wire  logic                    mclk,
  input  wire  logic                    reset_n,
  // Avalon-MM slave
  input  wire  logic [`POBS_ADDR_W-1:0] avs_address,
  input  wire  logic                    avs_read,
  input  wire  logic                    avs_write,
  input  wire  logic [31:0]             avs_writedata,
  input  wire  logic [3:0]              avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  // Automatic gain loop
  input  wire  logic                    agc_valid,
  input  wire  pobs_set_t               agc_value,
  // ADC sample stream
  input  wire  pobs_adc_s               adc_in,
  // Pixel stream to formatter
  output pobs_pix_s                     pix_out,
  // Total gain per half to analog stage
  output pobs_sum_t                     gain_right,
  output pobs_sum_t                     gain_left
);

  pobs_state_s st_ff;
  pobs_state_s nxt_st;

  logic      req;
  logic      wr_acc;
  pobs_sum_t cur_sum;
  pobs_adc_t win_data;
  logic      win_sat;
  pobs_set_t wval;
  pobs_set_t gsel_val;
  pobs_set_t osel_val;

  //////////////////////////////////////////////////////////////////////////////

  function automatic pobs_set_t pick(input pobs_sel_e s, input pobs_set_t a,
                                     input pobs_set_t r, input pobs_set_t l);
    pobs_set_t v;
    v = a;
    if (s == sel_right) begin
      v = r;
    end else if (s == sel_left) begin
      v = l;
    end
    return v;
  endfunction

  // Byte lanes 0 and 1 carry the 10-bit value
  function automatic pobs_set_t merge(input pobs_set_t old, input logic [15:0] wd,
                                      input logic [3:0] be);
    logic [15:0] m;
    m = {6'h00, old};
    if (be[0]) begin
      m[7:0] = wd[7:0];
    end
    if (be[1]) begin
      m[15:8] = wd[15:8];
    end
    return m[9:0];
  endfunction

  function automatic pobs_set_t clamp_off(input pobs_set_t v);
    return (v > `POBS_OFF_MAX) ? `POBS_OFF_MAX : v;
  endfunction

  function automatic logic [31:0] rd_word(input pobs_state_s s,
                                          input logic [`POBS_ADDR_W-1:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      `POBS_REG_GAIN_SEL: w[1:0] = s.gsel;
      `POBS_REG_GAIN_VAL: w[9:0] = pick(s.gsel, s.g_all, s.g_r, s.g_l);
      `POBS_REG_OFF_SEL:  w[1:0] = s.osel;
      `POBS_REG_OFF_VAL:  w[9:0] = pick(s.osel, s.o_all, s.o_r, s.o_l);
      `POBS_REG_CTRL: begin
        w[`POBS_CTRL_SHIFT_LSB+:3] = s.shift;
        w[`POBS_CTRL_FMT12_BIT]    = s.fmt12;
        w[`POBS_CTRL_AGC_BIT]      = s.agc_en;
      end
      `POBS_REG_STATUS: begin
        w[`POBS_STAT_SAT_BIT]       = s.sat_seen;
        w[`POBS_STAT_CNT_LSB+:16]   = s.pix_cnt;
      end
      `POBS_REG_GAIN_TOT: w = {5'h00, s.gl_tot, 5'h00, s.gr_tot};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  // Each access waits exactly one cycle, reads come from flip-flops
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~st_ff.ack;
  assign wr_acc          = avs_write & st_ff.ack;
  assign avs_readdata    = st_ff.rdata;
  assign pix_out         = st_ff.pix;
  assign gain_right      = st_ff.gr_tot;
  assign gain_left       = st_ff.gl_tot;

  assign gsel_val = pick(st_ff.gsel, st_ff.g_all, st_ff.g_r, st_ff.g_l);
  assign osel_val = pick(st_ff.osel, st_ff.o_all, st_ff.o_r, st_ff.o_l);

  // Tap 0 is the right half, tap 1 the left
  assign cur_sum = adc_in.tap ?
                   pobs_sum_t'(st_ff.o_all) + pobs_sum_t'(st_ff.o_l) :
                   pobs_sum_t'(st_ff.o_all) + pobs_sum_t'(st_ff.o_r);

  pobs_window u_window (
    .sample  (adc_in.data),
    .off_sum (cur_sum),
    .shift   (st_ff.shift),
    .fmt12   (st_ff.fmt12),
    .data    (win_data),
    .sat     (win_sat)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ack = req & ~st_ff.ack;
    wval       = 10'h000;
    if (req & ~st_ff.ack) begin
      nxt_st.rdata = avs_read ? rd_word(st_ff, avs_address) : 32'h0000_0000;
    end
    if (wr_acc) begin
      unique case (avs_address)
        `POBS_REG_GAIN_SEL: begin
          if (avs_byteenable[0] && avs_writedata[1:0] != 2'b11) begin
            nxt_st.gsel = pobs_sel_e'(avs_writedata[1:0]);
          end
        end
        `POBS_REG_GAIN_VAL: begin
          wval = merge(gsel_val, avs_writedata[15:0], avs_byteenable);
          unique case (st_ff.gsel)
            sel_all:   nxt_st.g_all = wval;
            sel_right: nxt_st.g_r   = wval;
            sel_left:  nxt_st.g_l   = wval;
          endcase
        end
        `POBS_REG_OFF_SEL: begin
          if (avs_byteenable[0] && avs_writedata[1:0] != 2'b11) begin
            nxt_st.osel = pobs_sel_e'(avs_writedata[1:0]);
          end
        end
        `POBS_REG_OFF_VAL: begin
          // Values above 600 are held at 600
          wval = clamp_off(merge(osel_val, avs_writedata[15:0], avs_byteenable));
          unique case (st_ff.osel)
            sel_all:   nxt_st.o_all = wval;
            sel_right: nxt_st.o_r   = wval;
            sel_left:  nxt_st.o_l   = wval;
          endcase
        end
        `POBS_REG_CTRL: begin
          if (avs_byteenable[0]) begin
            nxt_st.shift  = avs_writedata[`POBS_CTRL_SHIFT_LSB+:3];
            nxt_st.fmt12  = avs_writedata[`POBS_CTRL_FMT12_BIT];
            nxt_st.agc_en = avs_writedata[`POBS_CTRL_AGC_BIT];
          end
        end
        `POBS_REG_STATUS: begin
          if (avs_byteenable[0] && avs_writedata[`POBS_STAT_SAT_BIT]) begin
            nxt_st.sat_seen = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Loop loads the global gain on each agc_valid while enabled and wins over a same-cycle software write
    if (st_ff.agc_en && agc_valid) begin
      nxt_st.g_all = agc_value;
    end
    nxt_st.gr_tot    = pobs_sum_t'(st_ff.g_all) + pobs_sum_t'(st_ff.g_r);
    nxt_st.gl_tot    = pobs_sum_t'(st_ff.g_all) + pobs_sum_t'(st_ff.g_l);
    nxt_st.pix.valid = adc_in.valid;
    if (adc_in.valid) begin
      nxt_st.pix.half = adc_in.tap;
      nxt_st.pix.data = win_data;
      nxt_st.pix.sat  = win_sat;
      nxt_st.pix_cnt  = st_ff.pix_cnt + 16'h0001;
      // Set after the clear so a same-cycle event survives
      if (win_sat) begin
        nxt_st.sat_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_ff        <= '0;
      st_ff.g_all  <= `POBS_RST_SET;
      st_ff.g_r    <= `POBS_RST_SET;
      st_ff.g_l    <= `POBS_RST_SET;
      st_ff.o_all  <= `POBS_RST_SET;
      st_ff.o_r    <= `POBS_RST_SET;
      st_ff.o_l    <= `POBS_RST_SET;
      st_ff.shift  <= `POBS_RST_SHIFT;
      st_ff.fmt12  <= `POBS_RST_FMT12;
      st_ff.agc_en <= `POBS_RST_AGC;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  logic wr_full;
  logic agc_take;
  assign wr_full  = wr_acc && avs_byteenable == 4'hF;
  assign agc_take = st_ff.agc_en && agc_valid;

  property p_gain_store;
    wr_full && avs_address == `POBS_REG_GAIN_VAL && st_ff.gsel == sel_right && !agc_take
    |=> st_ff.g_r == $past(avs_writedata[9:0]) && $stable(st_ff.g_all);
  endproperty
  a_gain_store: assert property (p_gain_store) else $error("gain write lost");

  property p_auto_gain;
    agc_take && !wr_acc
    |=> st_ff.g_all == $past(agc_value) && $stable(st_ff.g_r) && $stable(st_ff.g_l);
  endproperty
  a_auto_gain: assert property (p_auto_gain) else $error("auto gain wrong");

  property p_off_clamp;
    wr_full && avs_address == `POBS_REG_OFF_VAL && st_ff.osel == sel_all
      && avs_writedata[9:0] > `POBS_OFF_MAX
    |=> st_ff.o_all == `POBS_OFF_MAX;
  endproperty
  a_off_clamp: assert property (p_off_clamp) else $error("offset not clamped");

  property p_off_store;
    wr_full && avs_address == `POBS_REG_OFF_VAL && st_ff.osel == sel_left
      && avs_writedata[9:0] <= `POBS_OFF_MAX
    |=> st_ff.o_l == $past(avs_writedata[9:0]) && $stable(st_ff.o_r);
  endproperty
  a_off_store: assert property (p_off_store) else $error("offset write lost");

  property p_right_sum;
    adc_in.valid && !adc_in.tap && st_ff.fmt12 && st_ff.shift == 3'h0
      && adc_in.data < 12'hA00
    |=> pix_out.data == $past(adc_in.data)
        + 12'((11'($past(st_ff.o_all)) + 11'($past(st_ff.o_r))) >> 2);
  endproperty
  a_right_sum: assert property (p_right_sum) else $error("right offset wrong");

  property p_left_sum;
    adc_in.valid && adc_in.tap && st_ff.fmt12 && st_ff.shift == 3'h0
      && adc_in.data < 12'hA00
    |=> pix_out.data == $past(adc_in.data)
        + 12'((11'($past(st_ff.o_all)) + 11'($past(st_ff.o_l))) >> 2) && pix_out.half;
  endproperty
  a_left_sum: assert property (p_left_sum) else $error("left offset wrong");

  property p_pass12;
    adc_in.valid && st_ff.fmt12 && st_ff.shift == 3'h0 && cur_sum == 11'h000
    |=> pix_out.valid && pix_out.data == $past(adc_in.data);
  endproperty
  a_pass12: assert property (p_pass12) else $error("12-bit pass wrong");

  property p_shift1;
    adc_in.valid && st_ff.fmt12 && st_ff.shift == 3'h1 && cur_sum == 11'h000
      && !adc_in.data[11]
    |=> pix_out.data == {$past(adc_in.data[10:0]), 1'b0};
  endproperty
  a_shift1: assert property (p_shift1) else $error("shift by one wrong");

  property p_sat;
    adc_in.valid && cur_sum == 11'h000 && |(adc_in.data & pobs_hi_mask(st_ff.shift))
    |=> pix_out.sat && pix_out.data == ($past(st_ff.fmt12) ? 12'hFFF : 12'h0FF);
  endproperty
  a_sat: assert property (p_sat) else $error("saturation missed");

  property p_eight;
    adc_in.valid && !st_ff.fmt12 && st_ff.shift == 3'h0 && cur_sum == 11'h000
    |=> pix_out.data == {4'h0, $past(adc_in.data[11:4])};
  endproperty
  a_eight: assert property (p_eight) else $error("8-bit window wrong");

  c_sat:   cover property (adc_in.valid ##1 pix_out.sat);
  c_write: cover property (wr_acc && avs_address == `POBS_REG_OFF_VAL);
  c_agc:   cover property (agc_take ##1 st_ff.g_all != $past(st_ff.g_all));
  c_rd:    cover property (avs_read && !avs_waitrequest);

endmodule

// ---- rtl/pobs_window.sv ----
`timescale 1ns/1ns
`include "pobs_map.svh"

module pobs_window
  import pobs_pkg::*;
(
  // Sample and offset
  input  wire pobs_adc_t  sample,
  input  wire pobs_sum_t  off_sum,
  // Mode
  input  wire logic [2:0] shift,
  input  wire logic       fmt12,
  // Result
  output pobs_adc_t       data,
  output logic            sat
);

  logic [12:0] biased;
  pobs_adc_t   clip;
  pobs_adc_t   moved;

  always_comb begin
    // Offset in 12-bit codes: 4 per code at 12 bit, 64 per code at 8 bit
    biased = {1'b0, sample} + 13'(off_sum >> `POBS_OFF_DROP);
    clip   = biased[12] ? 12'hFFF : biased[11:0];
    moved  = clip << pobs_shift_n(shift);
    sat    = |(clip & pobs_hi_mask(shift));
    if (sat) begin
      data = fmt12 ? 12'hFFF : 12'h0FF;
    end else if (fmt12) begin
      data = moved;
    end else begin
      data = {4'h0, moved[11:4]};
    end
  end

endmodule

// ---- test/pobs_adc_src.sv ----
`timescale 1ns/1ns

module pobs_adc_src
  import pobs_pkg::*;
(
  // Clock and reset
  input  wire logic      mclk,
  input  wire logic      reset_n,
  // Bench request
  input  wire logic      go,
  input  wire logic      tap,
  input  wire pobs_adc_t data,
  // Sample stream
  output pobs_adc_s      adc_in
);
  // Idle data toggles so a stale sample never looks valid by accident
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      adc_in <= '0;
    end else if (go) begin
      adc_in <= '{valid: 1'b1, tap: tap, data: data};
    end else begin
      adc_in.valid <= 1'b0;
      adc_in.data  <= ~adc_in.data;
    end
  end
endmodule

// ---- test/pobs_top_tb.sv ----
`timescale 1ns/1ns
`include "pobs_map.svh"

module pobs_top_tb;
  import pobs_pkg::*;
  logic        mclk, reset_n, avs_read, avs_write, agc_valid, go, tap;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [3:0]  avs_byteenable;
  logic        avs_waitrequest;
  pobs_set_t   agc_value;
  pobs_adc_t   sdata;
  pobs_adc_s   adc_in;
  pobs_pix_s   pix_out;
  pobs_sum_t   gain_right, gain_left;
  int          err_count, checks, npix;
  logic [11:0] dv [3] = '{12'h0A5, 12'h5A3, 12'hFF8};

  pobs_top u_dut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .agc_valid(agc_valid), .agc_value(agc_value),
    .adc_in(adc_in), .pix_out(pix_out), .gain_right(gain_right), .gain_left(gain_left));

  pobs_adc_src u_src (.mclk(mclk), .reset_n(reset_n), .go(go), .tap(tap), .data(sdata),
    .adc_in(adc_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  // Master waits on waitrequest; no fixed latency assumed
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    logic wt;
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wd;
    // Settled mid-cycle, these stand until the edge that ends the wait
    do begin
      @(negedge mclk);
      wt  = avs_waitrequest;
      rdv = avs_readdata;
      @(posedge mclk);
    end while (wt !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask

  // Reference datapath, written independently of the design
  function automatic logic [12:0] ref_pix(logic [11:0] d, int sum, int sc, logic f12);
    int b, n, v;
    logic s;
    b = d + (sum >> 2);
    if (b > 4095) b = 4095;
    n = (sc > 4) ? 0 : sc;
    s = (b >> (12 - n)) != 0;
    v = (b << n) & 4095;
    if (f12) return {s, s ? 12'hFFF : 12'(v)};
    return {s, s ? 12'h0FF : 12'(v >> 4)};
  endfunction

  task automatic pix(input logic t, input logic [11:0] d, input logic [12:0] e);
    @(posedge mclk);
    go    <= 1'b1;
    tap   <= t;
    sdata <= d;
    @(posedge mclk);
    go <= 1'b0;
    npix++;
    @(posedge mclk);
    #1;
    chk(pix_out.valid, 1'b1);
    chk(pix_out.half, t);
    chk({pix_out.sat, pix_out.data}, e);
    @(posedge mclk);
    #1;
    chk(pix_out.valid, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    #400000;
    err_count++;
    results();
  end

  initial begin
    reset_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 5'h00;
    avs_writedata = 32'h0; avs_byteenable = 4'hF; agc_valid = 1'b0; agc_value = 10'h000;
    go = 1'b0; tap = 1'b0; sdata = 12'h000; err_count = 0; checks = 0; npix = 0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    rd(`POBS_REG_CTRL, 32'h0);
    rd(`POBS_REG_GAIN_TOT, 32'h0);
    rd(5'h1C, 32'h0);
    rd(5'h05, 32'h0);
    // Gain selector and value port
    wr(`POBS_REG_GAIN_SEL, 32'h0);
    wr(`POBS_REG_GAIN_VAL, 32'h64);
    wr(`POBS_REG_GAIN_SEL, 32'h1);
    wr(`POBS_REG_GAIN_VAL, 32'h5);
    wr(`POBS_REG_GAIN_SEL, 32'h2);
    wr(`POBS_REG_GAIN_VAL, 32'h7);
    rd(`POBS_REG_GAIN_TOT, 32'h006B_0069);
    wr(`POBS_REG_GAIN_SEL, 32'h3);
    wr(`POBS_REG_GAIN_VAL, 32'h9);
    wr(5'h1C, 32'hFFFF_FFFF);
    rd(`POBS_REG_GAIN_VAL, 32'h9);
    // Auto gain touches the global gain only
    wr(`POBS_REG_CTRL, 32'h10);
    @(posedge mclk);
    agc_valid <= 1'b1;
    agc_value <= 10'h0C8;
    @(posedge mclk);
    agc_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(gain_right, 11'h0CD);
    chk(gain_left, 11'h0D1);
    rd(`POBS_REG_GAIN_VAL, 32'h9);
    wr(`POBS_REG_CTRL, 32'h0);
    @(posedge mclk);
    agc_valid <= 1'b1;
    agc_value <= 10'h032;
    @(posedge mclk);
    agc_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(gain_right, 11'h0CD);
    // Lane 1 alone merges into the selected left gain
    @(posedge mclk);
    avs_byteenable <= 4'h2;
    wr(`POBS_REG_GAIN_VAL, 32'h0000_0300);
    avs_byteenable <= 4'hF;
    rd(`POBS_REG_GAIN_VAL, 32'h309);
    // Zero offsets: plain windows and saturation
    for (int f = 0; f < 2; f++) begin
      for (int s = 0; s < 2; s++) begin
        wr(`POBS_REG_CTRL, 32'(s) | (32'(f) << 3));
        pix(1'b0, dv[1], ref_pix(dv[1], 0, s, f[0]));
        pix(1'b1, dv[2], ref_pix(dv[2], 0, s, f[0]));
      end
    end
    // Offsets; sums kept within 600 by software
    wr(`POBS_REG_OFF_SEL, 32'h0);
    wr(`POBS_REG_OFF_VAL, 32'h2BC);
    rd(`POBS_REG_OFF_VAL, 32'h258);
    wr(`POBS_REG_OFF_VAL, 32'h28);
    wr(`POBS_REG_OFF_SEL, 32'h1);
    wr(`POBS_REG_OFF_VAL, 32'h8);
    wr(`POBS_REG_OFF_SEL, 32'h2);
    wr(`POBS_REG_OFF_VAL, 32'h4);
    rd(`POBS_REG_OFF_VAL, 32'h4);
    // Every format, every shift code (5..7 too), both halves
    for (int f = 0; f < 2; f++) begin
      for (int s = 0; s < 8; s++) begin
        wr(`POBS_REG_CTRL, 32'(s) | (32'(f) << 3));
        for (int i = 0; i < 3; i++) begin
          pix(1'b0, dv[i], ref_pix(dv[i], 48, s, f[0]));
          pix(1'b1, dv[i], ref_pix(dv[i], 44, s, f[0]));
        end
      end
    end
    bus(1'b0, `POBS_REG_STATUS, 32'h0);
    chk(rdv[0], 1'b1);
    chk(rdv[31:16], npix);
    wr(`POBS_REG_STATUS, 32'h1);
    bus(1'b0, `POBS_REG_STATUS, 32'h0);
    chk(rdv[0], 1'b0);
    results();
  end
endmodule
